// >>> inc/adp_pkg.sv
package adp_pkg;

	// ****************************************
	// widths and depths
	// ****************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int SAMPLE_W = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int LEVEL_W = 3;
	localparam int VOL_W = 6;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [23:0] OFF_STD_CONFIG = 24'h320100;
	localparam logic [23:0] OFF_STD_LOAD = 24'h320104;
	localparam logic [23:0] OFF_SOFT_HOLD = 24'h320108;
	localparam logic [23:0] OFF_STATUS = 24'h320110;
	localparam logic [23:0] OFF_PATH_CTRL = 24'h32058c;
	localparam logic [23:0] OFF_TUNER_BOOST = 24'h320628;

	// ****************************************
	// fields, commands and reset values
	// ****************************************
	localparam int DAC_EN_BIT = 12;
	localparam int SER_DIRECT_BIT = 14;
	localparam int VOL_LSB = 0;
	localparam logic [15:0] CMD_ONE = 16'h0001;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] CODE_NICAM = 16'h0010;
	localparam logic [15:0] CODE_FM = 16'h0020;
	localparam logic [15:0] CODE_BTSC = 16'h0001;
	localparam logic [15:0] CODE_EIAJ = 16'h0002;
	localparam logic [15:0] CODE_A2 = 16'h0004;

	// ****************************************
	// rate derivation
	// ****************************************
	localparam longint PLL_FREQ_HZ = 200000000;
	localparam int PWM_DIV = 18;
	localparam int OSR_DIV = 128;
	localparam longint DAC_RATE_HZ = PLL_FREQ_HZ / (PWM_DIV * OSR_DIV);
	localparam logic [4:0] PWM_LAST = 5'(PWM_DIV - 1);
	localparam logic [6:0] OSR_LAST = 7'(OSR_DIV - 1);

	typedef enum logic [2:0] {
		ADP_STD_NONE,
		ADP_STD_NICAM,
		ADP_STD_FM,
		ADP_STD_BTSC,
		ADP_STD_EIAJ,
		ADP_STD_A2
	} adp_std_t;

endpackage : adp_pkg

// >>> inc/adp_stream_if.sv
`timescale 1ns/1ps
interface adp_stream_if;
	logic in_valid;
	logic in_ready;
	logic [adp_pkg::SAMPLE_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [adp_pkg::SAMPLE_W-1:0] out_data;
	logic flush;
	logic [adp_pkg::LEVEL_W-1:0] level;

	modport fifo (
		input in_valid, in_data, out_ready, flush,
		output in_ready, out_valid, out_data, level
	);
	modport user (
		output in_valid, in_data, out_ready, flush,
		input in_ready, out_valid, out_data, level
	);
endinterface : adp_stream_if

// >>> core/adp_fifo.sv
`timescale 1ns/1ps
module adp_fifo #(
	parameter int WIDTH = adp_pkg::SAMPLE_W,
	parameter int DEPTH = adp_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	adp_stream_if.fifo s
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	// handshake terms and pointer updates
	always_comb
	begin
		push = s.in_valid && s.in_ready;
		pop = s.out_valid && s.out_ready;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (s.flush)
		begin
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end
		else
		begin
			if (push)
				wr_next = PW'((wr_reg + 1'b1) % DEPTH);
			if (pop)
				rd_next = PW'((rd_reg + 1'b1) % DEPTH);
			if (push && !pop)
				cnt_next = cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_next = cnt_reg - 1'b1;
		end
	end

	// pointer registers
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage, written only on an accepted push
	always_ff @(posedge clk_sys)
	begin
		if (push && !s.flush)
			mem[wr_reg] <= s.in_data;
	end

	assign s.in_ready = (cnt_reg != (PW+1)'(DEPTH)) && !s.flush;
	assign s.out_valid = (cnt_reg != '0) && !s.flush;
	assign s.out_data = mem[rd_reg];
	assign s.level = adp_pkg::LEVEL_W'(cnt_reg);
endmodule : adp_fifo

// >>> core/adp_rate_div.sv
`timescale 1ns/1ps
module adp_rate_div (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic run,
	output logic tick
);
	logic [4:0] pwm_reg, pwm_next;
	logic [6:0] osr_reg, osr_next;
	logic tick_next;

	always_comb
	begin
		pwm_next = pwm_reg;
		osr_next = osr_reg;
		tick_next = 1'b0;
		if (!run)
		begin
			pwm_next = '0;
			osr_next = '0;
		end
		else if (pwm_reg == adp_pkg::PWM_LAST)
		begin
			pwm_next = '0;
			osr_next = osr_reg + 1'b1;
			tick_next = (osr_reg == adp_pkg::OSR_LAST);
		end
		else
			pwm_next = pwm_reg + 1'b1;
	end

	// divider registers
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			pwm_reg <= '0;
			osr_reg <= '0;
			tick <= 1'b0;
		end
		else
		begin
			pwm_reg <= pwm_next;
			osr_reg <= osr_next;
			tick <= tick_next;
		end
	end
endmodule : adp_rate_div

// >>> core/adp_top.sv
`timescale 1ns/1ps
module adp_top (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [23:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic ser_valid,
	input wire logic [31:0] ser_data,
	output logic ser_ready,
	input wire logic dma_valid,
	input wire logic [31:0] dma_data,
	output logic dma_ready,
	output logic [31:0] dac_data,
	output logic dac_strobe,
	output logic dac_enable,
	output adp_pkg::adp_std_t active_standard,
	output logic soft_hold,
	output logic tuner_boost,
	output logic [5:0] volume_atten
);

	// ****************************************
	// standard code decoder
	// ****************************************

	// maps a written code onto a standard
	function automatic adp_pkg::adp_std_t decode_std(
		input logic [15:0] code
	);
		adp_pkg::adp_std_t s;
		s = adp_pkg::ADP_STD_NONE;
		if (code == adp_pkg::CODE_NICAM)
			s = adp_pkg::ADP_STD_NICAM;
		else if (code == adp_pkg::CODE_FM)
			s = adp_pkg::ADP_STD_FM;
		else if (code == adp_pkg::CODE_BTSC)
			s = adp_pkg::ADP_STD_BTSC;
		else if (code == adp_pkg::CODE_EIAJ)
			s = adp_pkg::ADP_STD_EIAJ;
		else if (code == adp_pkg::CODE_A2)
			s = adp_pkg::ADP_STD_A2;
		return s;
	endfunction : decode_std

	// ****************************************
	// declarations
	// ****************************************
	logic [15:0] std_cfg_reg, std_cfg_next;
	logic [15:0] std_load_reg, std_load_next;
	logic [15:0] hold_reg, hold_next;
	logic [15:0] path_reg, path_next;
	logic [15:0] boost_reg, boost_next;
	logic [15:0] rdata_next;
	adp_pkg::adp_std_t std_next;
	logic hold_on_next;
	logic boost_on_next;
	logic [5:0] vol_next;
	logic path_on;
	logic ser_sel;
	logic tick;

	logic [31:0] stage_data_reg, stage_data_next;
	logic stage_valid_reg, stage_valid_next;
	logic ser_ready_next, dma_ready_next;
	logic [31:0] dac_data_next;
	logic dac_strobe_next;
	logic dac_enable_next;
	logic take_ser, take_dma;

	adp_stream_if fq ();

	// ****************************************
	// register writes
	// ****************************************

	// next values of the software registers
	always_comb
	begin
		std_cfg_next = std_cfg_reg;
		std_load_next = std_load_reg;
		hold_next = hold_reg;
		path_next = path_reg;
		boost_next = boost_reg;
		std_next = active_standard;
		if (reg_wr)
		begin
			unique case (reg_addr)
				adp_pkg::OFF_STD_CONFIG: std_cfg_next = reg_wdata;
				adp_pkg::OFF_STD_LOAD: std_load_next = reg_wdata;
				adp_pkg::OFF_SOFT_HOLD: hold_next = reg_wdata;
				adp_pkg::OFF_PATH_CTRL: path_next = reg_wdata;
				adp_pkg::OFF_TUNER_BOOST: boost_next = reg_wdata;
				default: ;
			endcase
		end
		if (reg_wr && reg_addr == adp_pkg::OFF_STD_LOAD
			&& reg_wdata == adp_pkg::CMD_ONE)
			std_next = decode_std(std_cfg_reg);
	end

	// derived control levels
	always_comb
	begin
		hold_on_next = (hold_next == adp_pkg::CMD_ONE);
		boost_on_next = (boost_next == adp_pkg::CMD_ONE);
		vol_next = path_next[adp_pkg::VOL_LSB +: adp_pkg::VOL_W];
	end

	// software register state
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			std_cfg_reg <= adp_pkg::REG_RESET;
			std_load_reg <= adp_pkg::REG_RESET;
			hold_reg <= adp_pkg::REG_RESET;
			path_reg <= adp_pkg::REG_RESET;
			boost_reg <= adp_pkg::REG_RESET;
			active_standard <= adp_pkg::ADP_STD_NONE;
			soft_hold <= 1'b0;
			tuner_boost <= 1'b0;
			volume_atten <= '0;
		end
		else
		begin
			std_cfg_reg <= std_cfg_next;
			std_load_reg <= std_load_next;
			hold_reg <= hold_next;
			path_reg <= path_next;
			boost_reg <= boost_next;
			active_standard <= std_next;
			soft_hold <= hold_on_next;
			tuner_boost <= boost_on_next;
			volume_atten <= vol_next;
		end
	end

	// ****************************************
	// register reads
	// ****************************************

	// read mux, unmapped addresses read zero
	always_comb
	begin
		rdata_next = '0;
		if (reg_rd)
		begin
			unique case (reg_addr)
				adp_pkg::OFF_STD_CONFIG: rdata_next = std_cfg_reg;
				adp_pkg::OFF_STD_LOAD: rdata_next = std_load_reg;
				adp_pkg::OFF_SOFT_HOLD: rdata_next = hold_reg;
				adp_pkg::OFF_PATH_CTRL: rdata_next = path_reg;
				adp_pkg::OFF_TUNER_BOOST: rdata_next = boost_reg;
				adp_pkg::OFF_STATUS:
					rdata_next = {6'h00, stage_valid_reg, dac_enable,
						3'(active_standard), 2'h0, fq.level};
				default: ;
			endcase
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			reg_rdata <= '0;
		else
			reg_rdata <= rdata_next;
	end

	// ****************************************
	// source selection
	// ****************************************

	// path on unless disabled or held
	assign path_on = path_reg[adp_pkg::DAC_EN_BIT] && !soft_hold;
	assign ser_sel = path_reg[adp_pkg::SER_DIRECT_BIT];

	// accepted samples from each source
	always_comb
	begin
		take_ser = ser_valid && ser_ready;
		take_dma = dma_valid && dma_ready;
	end

	// staging register ahead of the fifo
	always_comb
	begin
		stage_data_next = stage_data_reg;
		stage_valid_next = stage_valid_reg;
		if (stage_valid_reg && fq.in_ready)
			stage_valid_next = 1'b0;
		if (take_ser)
		begin
			stage_data_next = ser_data;
			stage_valid_next = 1'b1;
		end
		else if (take_dma)
		begin
			stage_data_next = dma_data;
			stage_valid_next = 1'b1;
		end
		if (!path_on)
			stage_valid_next = 1'b0;
	end

	// ready offered only to the selected source
	always_comb
	begin
		ser_ready_next = path_on && ser_sel && !stage_valid_next;
		dma_ready_next = path_on && !ser_sel && !stage_valid_next;
	end

	// staging and ready registers
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			stage_data_reg <= '0;
			stage_valid_reg <= 1'b0;
			ser_ready <= 1'b0;
			dma_ready <= 1'b0;
		end
		else
		begin
			stage_data_reg <= stage_data_next;
			stage_valid_reg <= stage_valid_next;
			ser_ready <= ser_ready_next;
			dma_ready <= dma_ready_next;
		end
	end

	// ****************************************
	// sample fifo and rate divider
	// ****************************************

	// fifo fill and drain hookup
	assign fq.in_valid = stage_valid_reg;
	assign fq.in_data = stage_data_reg;
	assign fq.flush = !path_on;
	assign fq.out_ready = tick && path_on;

	adp_fifo #(
		.WIDTH(adp_pkg::SAMPLE_W),
		.DEPTH(adp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.s(fq.fifo)
	);

	adp_rate_div u_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.run(path_on),
		.tick(tick)
	);

	// ****************************************
	// dac output stage
	// ****************************************

	// one sample per rate tick
	always_comb
	begin
		dac_data_next = dac_data;
		dac_strobe_next = 1'b0;
		dac_enable_next = path_on;
		if (fq.out_valid && fq.out_ready)
		begin
			dac_data_next = fq.out_data;
			dac_strobe_next = 1'b1;
		end
		if (!path_on)
		begin
			dac_data_next = '0;
			dac_strobe_next = 1'b0;
		end
	end

	// dac output registers
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			dac_data <= '0;
			dac_strobe <= 1'b0;
			dac_enable <= 1'b0;
		end
		else
		begin
			dac_data <= dac_data_next;
			dac_strobe <= dac_strobe_next;
			dac_enable <= dac_enable_next;
		end
	end

endmodule : adp_top

// >>> verification/adp_sva.sv
`timescale 1ns/1ps
module adp_sva (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [23:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic ser_ready,
	input wire logic dma_ready,
	input wire logic [31:0] dac_data,
	input wire logic dac_strobe,
	input wire logic dac_enable,
	input wire adp_pkg::adp_std_t active_standard,
	input wire logic soft_hold,
	input wire logic tuner_boost,
	input wire logic [5:0] volume_atten
);
	// ****************************************
	// helper state
	// ****************************************
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	logic [15:0] cfg_q;
	logic [15:0] gap_q;
	logic seen_q;

	// expected decode of a loaded code
	function automatic adp_pkg::adp_std_t dec(logic [15:0] c);
		case (c)
			adp_pkg::CODE_NICAM: dec = adp_pkg::ADP_STD_NICAM;
			adp_pkg::CODE_FM: dec = adp_pkg::ADP_STD_FM;
			adp_pkg::CODE_BTSC: dec = adp_pkg::ADP_STD_BTSC;
			adp_pkg::CODE_EIAJ: dec = adp_pkg::ADP_STD_EIAJ;
			adp_pkg::CODE_A2: dec = adp_pkg::ADP_STD_A2;
			default: dec = adp_pkg::ADP_STD_NONE;
		endcase
	endfunction : dec

	// last config word and cycles since the previous strobe
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			cfg_q <= 16'h0000;
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == adp_pkg::OFF_STD_CONFIG)
				cfg_q <= reg_wdata;
			gap_q <= (dac_strobe || !dac_enable) ? 16'h0000 : gap_q + 16'h0001;
			seen_q <= dac_enable && (seen_q || dac_strobe);
		end
	end

	chk_off_quiet: assert property (
		!dac_enable && !$past(dac_enable) |-> !dac_strobe && dac_data == 32'h0)
		else $error("dac output active while path off");
	chk_strobe_pulse: assert property (dac_strobe |=> !dac_strobe)
		else $error("dac strobe longer than one cycle");
	chk_strobe_gap: assert property (
		dac_strobe && seen_q |-> (gap_q % 2304) == 2303)
		else $error("dac strobe off the sample grid");
	chk_std_load: assert property (
		reg_wr && reg_addr == adp_pkg::OFF_STD_LOAD && reg_wdata == 16'h0001
		|=> active_standard == dec(cfg_q))
		else $error("loaded standard wrong");
	chk_std_keep: assert property (
		!(reg_wr && reg_addr == adp_pkg::OFF_STD_LOAD) |=> $stable(active_standard))
		else $error("standard changed without load");
	chk_hold_write: assert property (
		reg_wr && reg_addr == adp_pkg::OFF_SOFT_HOLD
		|=> soft_hold == ($past(reg_wdata) == 16'h0001))
		else $error("soft hold not written");
	chk_hold_keep: assert property (
		!(reg_wr && reg_addr == adp_pkg::OFF_SOFT_HOLD) |=> soft_hold == $past(soft_hold))
		else $error("soft hold changed by itself");
	chk_hold_gate: assert property (
		soft_hold [*2] |-> !dac_enable && !ser_ready && !dma_ready)
		else $error("path active during soft hold");
	chk_boost_write: assert property (
		reg_wr && reg_addr == adp_pkg::OFF_TUNER_BOOST
		|=> tuner_boost == ($past(reg_wdata) == 16'h0001))
		else $error("tuner boost not written");
	chk_vol_write: assert property (
		reg_wr && reg_addr == adp_pkg::OFF_PATH_CTRL |=> volume_atten == 6'($past(reg_wdata)))
		else $error("volume not written");
endmodule : adp_sva

bind adp_top adp_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .ser_ready(ser_ready), .dma_ready(dma_ready),
	.dac_data(dac_data), .dac_strobe(dac_strobe), .dac_enable(dac_enable),
	.active_standard(active_standard), .soft_hold(soft_hold), .tuner_boost(tuner_boost),
	.volume_atten(volume_atten));

// >>> verification/adp_dac_model.sv
`timescale 1ns/1ps
module adp_dac_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [31:0] dac_data,
	input wire logic dac_strobe
);
	// ****************************************
	// dac sink
	// ****************************************
	logic [31:0] got_q[$];
	longint at_q[$];
	longint cyc = 0;

	// one word taken per strobe, with its cycle
	always @(posedge clk_sys)
	begin
		cyc = cyc + 1;
		if (reset_n && dac_strobe)
		begin
			got_q.push_back(dac_data);
			at_q.push_back(cyc);
		end
	end
endmodule : adp_dac_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ****************************************
	// signals and instances
	// ****************************************
	logic clk_sys, reset_n, reg_wr, reg_rd, ser_valid, dma_valid;
	logic ser_ready, dma_ready, dac_strobe, dac_enable, soft_hold, tuner_boost;
	logic [23:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd;
	logic [31:0] ser_data, dma_data, dac_data;
	logic [5:0] volume_atten;
	adp_pkg::adp_std_t active_standard, prev;
	int error_cnt, n_checks, k;
	logic [15:0] codes[6] = '{adp_pkg::CODE_NICAM, adp_pkg::CODE_FM, adp_pkg::CODE_BTSC,
		adp_pkg::CODE_EIAJ, adp_pkg::CODE_A2, 16'h0008};
	adp_pkg::adp_std_t stds[6] = '{adp_pkg::ADP_STD_NICAM, adp_pkg::ADP_STD_FM,
		adp_pkg::ADP_STD_BTSC, adp_pkg::ADP_STD_EIAJ, adp_pkg::ADP_STD_A2, adp_pkg::ADP_STD_NONE};

	adp_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
		.dac_data(dac_data), .dac_strobe(dac_strobe), .dac_enable(dac_enable),
		.active_standard(active_standard), .soft_hold(soft_hold),
		.tuner_boost(tuner_boost), .volume_atten(volume_atten));
	adp_dac_model dac (.clk_sys(clk_sys), .reset_n(reset_n), .dac_data(dac_data),
		.dac_strobe(dac_strobe));

	// 200 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// tasks
	// ****************************************
	task end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task check_word(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check_word

	task check_std(input adp_pkg::adp_std_t g, input adp_pkg::adp_std_t e);
		check_word(32'(g), 32'(e));
	endtask : check_std

	task reg_write(input logic [23:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask : reg_write

	task reg_read(input logic [23:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask : reg_read

	// one sample held until taken; the unselected source is offered too
	task stream(input bit to_ser, input logic [31:0] base);
		int n;
		logic other;
		k = dac.got_q.size();
		other = 1'b0;
		ser_valid <= 1'b1;
		dma_valid <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			if (to_ser)
				ser_data <= base + i;
			else
				dma_data <= base + i;
			n = 0;
			do
			begin
				@(posedge clk_sys);
				n++;
				other |= to_ser ? dma_ready : ser_ready;
			end while ((to_ser ? ser_ready : dma_ready) !== 1'b1 && n < 3000);
		end
		ser_valid <= 1'b0;
		dma_valid <= 1'b0;
		repeat (6 * 2304) @(posedge clk_sys);
		check_word(32'(other), 32'h0);
		check_word(32'(dac.got_q.size() - k), 32'h6);
		for (int i = 0; i < 6; i++)
			check_word(dac.got_q[k + i], base + i);
		for (int i = 1; i < 6; i++)
			check_word(32'(dac.at_q[k + i] - dac.at_q[k + i - 1]), 32'd2304);
	endtask : stream

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		end_sim;
	end

	initial
	begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, ser_valid, dma_valid} = 4'h0;
		{reg_addr, reg_wdata, ser_data, dma_data} = '0;
		error_cnt = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		reg_read(adp_pkg::OFF_PATH_CTRL, rd);
		check_word(32'(rd), 32'h0);
		check_word(32'(dac_enable), 32'h0);
		reg_read(24'h320200, rd);
		check_word(32'(rd), 32'h0);
		$display("test reset done");
		// setup order: boost, select, load, hold, release, volume
		reg_write(adp_pkg::OFF_TUNER_BOOST, 16'h0001);
		check_word(32'(tuner_boost), 32'h1);
		prev = adp_pkg::ADP_STD_NONE;
		for (int i = 0; i < 6; i++)
		begin
			reg_write(adp_pkg::OFF_STD_CONFIG, codes[i]);
			check_std(active_standard, prev);
			reg_write(adp_pkg::OFF_STD_LOAD, 16'h0001);
			check_std(active_standard, stds[i]);
			prev = stds[i];
			reg_write(adp_pkg::OFF_SOFT_HOLD, 16'h0001);
			check_word(32'(soft_hold), 32'h1);
			reg_write(adp_pkg::OFF_SOFT_HOLD, 16'h0000);
			check_word(32'(soft_hold), 32'h0);
		end
		reg_write(adp_pkg::OFF_PATH_CTRL, 16'h003f);
		check_word(32'(volume_atten), 32'h3f);
		reg_write(adp_pkg::OFF_PATH_CTRL, 16'h0000);
		check_word(32'(volume_atten), 32'h0);
		$display("test setup done");
		reg_write(adp_pkg::OFF_PATH_CTRL, 16'h4000);
		{ser_valid, dma_valid} <= 2'b11;
		repeat (2400) @(posedge clk_sys);
		check_word(32'(dac.got_q.size()), 32'h0);
		check_word({ser_ready, dma_ready, dac_data[29:0]}, 32'h0);
		{ser_valid, dma_valid} <= 2'b00;
		@(posedge clk_sys);
		$display("test path off done");
		// sources paced by the dac rate through ready
		reg_write(adp_pkg::OFF_PATH_CTRL, 16'h5000);
		@(posedge clk_sys); // dac_enable lags the register write by one cycle
		check_word(32'(dac_enable), 32'h1);
		stream(1'b1, 32'ha5a50000);
		$display("test serial route done");
		reg_write(adp_pkg::OFF_PATH_CTRL, 16'h1000);
		stream(1'b0, 32'h3c3c0100);
		$display("test dma route done");
		k = dac.got_q.size();
		reg_write(adp_pkg::OFF_SOFT_HOLD, 16'h0001);
		@(posedge clk_sys); // dac_enable lags soft_hold by one cycle
		check_word(32'(dac_enable), 32'h0);
		repeat (2400) @(posedge clk_sys);
		reg_write(adp_pkg::OFF_SOFT_HOLD, 16'h0000);
		@(posedge clk_sys); // dac_enable lags soft_hold by one cycle
		check_word(32'(dac_enable), 32'h1);
		check_word(32'(dac.got_q.size() - k), 32'h0);
		// status: path live, fifo empty, standard none after the last load
		reg_read(adp_pkg::OFF_STATUS, rd);
		check_word(32'(rd), 32'h0100);
		$display("test soft hold done");
		end_sim;
	end
endmodule : testbench
